// ---- frame_pulse_alignment_control.sv ----
// Alignment control for three top-of-frame pulse generators
`timescale 1ns/100ps
module frame_pulse_alignment_control #(
  parameter int err_width = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input frame_align_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic line_tick,
  input wire logic frame_tick,
  input wire logic horizontal_only,
  input wire logic reference_loss,
  input wire logic same_reference,
  input wire logic [err_width-1:0] frame_error,
  input wire logic [2:0] misalign_window_code,
  output frame_align_pkg::frame_one_ctl_s frame_one_ctl,
  output logic misalign_report,
  output logic [1:0] frame_two_mode,
  output logic [1:0] frame_three_mode,
  output logic frame_two_init_out,
  output logic frame_three_init_out
);
  import frame_align_pkg::*;

  logic [1:0] frame_one_align_select_q;
  logic [1:0] frame_one_resync_policy_q;
  logic frame_one_slew_direction_q;
  logic [1:0] frame_two_align_select_q;
  logic [1:0] frame_three_align_select_q;
  logic ref_lost_q;
  logic [1:0] eff_one_select;
  logic near_expected;
  logic error_small;
  logic misaligned;
  logic [err_width:0] window_limit;
  lock_action_e action_d;
  logic two_start;
  logic three_start;
  logic [1:0] h_only_sync_q;
  logic [1:0] ref_loss_sync_q;
  logic [1:0] same_ref_sync_q;
  logic h_only_s;
  logic ref_loss_s;
  logic same_ref_s;
  logic [err_width-1:0] line_cycles_q;
  logic [err_width-1:0] line_len_q;
  logic [err_width+1:0] near_limit;
  logic [line_count_width-1:0] line_pos_q;
  logic [line_count_width-1:0] frame_lines_q;

  function automatic logic [err_width:0] pow_two(input logic [2:0] code);
    pow_two = (err_width+1)'(1) << code;
  endfunction : pow_two

  // Init write starts a pulse unless the same write selects never align
  function automatic logic init_start(input reg_req_s req, input logic [7:0] addr);
    init_start = req.wr_en && req.addr == addr && req.wdata[init_bit]
                 && req.wdata[align_sel_lsb +: 2] != align_never;
  endfunction : init_start

  // End after one frame of lines plus one more line
  function automatic logic pulse_done(input logic counting, input logic tick,
                                      input logic [line_count_width-1:0] lines,
                                      input logic [line_count_width-1:0] limit);
    pulse_done = counting && tick && lines == limit;
  endfunction : pulse_done

  assign h_only_s = h_only_sync_q[1];
  assign ref_loss_s = ref_loss_sync_q[1];
  assign same_ref_s = same_ref_sync_q[1];
  assign window_limit = pow_two(misalign_window_code);
  assign error_small = {1'b0, frame_error} < window_limit;
  assign misaligned = {1'b0, frame_error} > window_limit;
  // Two-line window from the measured line length in clocks
  assign near_limit = {2'b00, line_len_q} * (err_width+2)'(near_lines);
  assign near_expected = {2'b00, frame_error} < near_limit;
  assign eff_one_select = h_only_s ? align_never : frame_one_align_select_q;
  assign two_start = init_start(reg_req, frame_two_alignment_control_addr);
  assign three_start = init_start(reg_req, frame_three_alignment_control_addr);

  // Register writes; reserved and init bits are not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_one_align_select_q <= align_sel_reset;
      frame_one_resync_policy_q <= resync_reset;
      frame_one_slew_direction_q <= slew_reset;
      frame_two_align_select_q <= align_sel_reset;
      frame_three_align_select_q <= align_sel_reset;
    end else if (reg_req.wr_en) begin
      if (reg_req.addr == frame_one_alignment_control_addr) begin
        frame_one_align_select_q <= reg_req.wdata[align_sel_lsb +: 2];
        frame_one_resync_policy_q <= reg_req.wdata[resync_lsb +: 2];
        frame_one_slew_direction_q <= reg_req.wdata[slew_bit];
      end else if (reg_req.addr == frame_two_alignment_control_addr) begin
        frame_two_align_select_q <= reg_req.wdata[align_sel_lsb +: 2];
      end else if (reg_req.addr == frame_three_alignment_control_addr) begin
        frame_three_align_select_q <= reg_req.wdata[align_sel_lsb +: 2];
      end
    end
  end

  // Read-back; one-cycle latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        if (reg_req.addr == frame_one_alignment_control_addr) begin
          reg_rdata <= {2'h0, frame_one_align_select_q, frame_one_resync_policy_q,
                        frame_one_slew_direction_q, 1'b0};
        end else if (reg_req.addr == frame_two_alignment_control_addr) begin
          reg_rdata <= {2'h0, frame_two_align_select_q, 4'h0};
        end else if (reg_req.addr == frame_three_alignment_control_addr) begin
          reg_rdata <= {2'h0, frame_three_align_select_q, 4'h0};
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

  // Level inputs from the reference side pass two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_only_sync_q <= 2'b00;
      ref_loss_sync_q <= 2'b00;
      same_ref_sync_q <= 2'b00;
    end else begin
      h_only_sync_q <= {h_only_sync_q[0], horizontal_only};
      ref_loss_sync_q <= {ref_loss_sync_q[0], reference_loss};
      same_ref_sync_q <= {same_ref_sync_q[0], same_reference};
    end
  end

  // Line length in clocks; saturates if line ticks stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_cycles_q <= '0;
      line_len_q <= '0;
    end else if (line_tick) begin
      line_cycles_q <= err_width'(1);
      line_len_q <= line_cycles_q;
    end else if (line_cycles_q != '1) begin
      line_cycles_q <= line_cycles_q + err_width'(1);
    end
  end

  // Lines per frame, the line that opens the frame included
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_pos_q <= '0;
      frame_lines_q <= '0;
    end else if (frame_tick) begin
      line_pos_q <= '0;
      frame_lines_q <= line_pos_q + line_count_width'(line_tick);
    end else if (line_tick && line_pos_q != '1) begin
      line_pos_q <= line_pos_q + line_count_width'(1);
    end
  end

  // Remember a momentary reference loss until the first frame tick after the reference returns
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_lost_q <= 1'b0;
    end else if (ref_loss_s) begin
      ref_lost_q <= 1'b1;
    end else if (frame_tick) begin
      ref_lost_q <= 1'b0;
    end
  end

  // Lock action chosen on first frame after the reference returns
  always_comb begin
    action_d = act_none;
    if (ref_lost_q && !ref_loss_s && frame_tick && eff_one_select != align_never) begin
      if (same_ref_s && near_expected) begin
        case (frame_one_resync_policy_q)
          2'h0: action_d = act_drift;
          2'h1: action_d = error_small ? act_drift : act_crash;
          default: action_d = act_crash;
        endcase
      end else begin
        action_d = act_slew;
      end
    end
  end

  // First pulse control outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_one_ctl <= '0;
      misalign_report <= 1'b0;
    end else begin
      misalign_report <= misaligned;
      frame_one_ctl.realign_now <= frame_tick && (eff_one_select == align_always
        || (eff_one_select == align_auto && misaligned));
      frame_one_ctl.drift_lock <= action_d == act_drift;
      frame_one_ctl.crash_lock <= action_d == act_crash;
      if (action_d == act_slew) begin
        frame_one_ctl.slew_active <= 1'b1;
        frame_one_ctl.vcxo_rail_high <= frame_one_slew_direction_q;
      end else if (!misaligned) begin
        frame_one_ctl.slew_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_two_mode <= align_sel_reset;
      frame_three_mode <= align_sel_reset;
    end else begin
      frame_two_mode <= frame_two_align_select_q;
      frame_three_mode <= frame_three_align_select_q;
    end
  end

  // One-shot init pulse timer, one each for the second and third pulse generators
  logic [1:0] wait_line_q;
  logic [1:0] counting_q;
  logic [line_count_width-1:0] lines_q [2];
  logic [1:0] start_v;
  logic [1:0] done_v;
  assign start_v = {three_start, two_start};
  assign done_v[0] = pulse_done(counting_q[0], line_tick, lines_q[0], frame_lines_q);
  assign done_v[1] = pulse_done(counting_q[1], line_tick, lines_q[1], frame_lines_q);

  // Part line before counting starts gives the extra zero-to-one line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_line_q <= 2'b00;
      counting_q <= 2'b00;
      lines_q[0] <= '0;
      lines_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (start_v[i]) begin
          wait_line_q[i] <= 1'b1;
          counting_q[i] <= 1'b0;
          lines_q[i] <= '0;
        end else if (wait_line_q[i] && line_tick) begin
          wait_line_q[i] <= 1'b0;
          counting_q[i] <= 1'b1;
        end else if (done_v[i]) begin
          counting_q[i] <= 1'b0;
        end else if (counting_q[i] && line_tick) begin
          lines_q[i] <= lines_q[i] + line_count_width'(1);
        end
      end
    end
  end

  // A new init write mid-pulse keeps the output high and rearms the timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_two_init_out <= 1'b0;
    end else if (two_start) begin
      frame_two_init_out <= 1'b1;
    end else if (done_v[0]) begin
      frame_two_init_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_three_init_out <= 1'b0;
    end else if (three_start) begin
      frame_three_init_out <= 1'b1;
    end else if (done_v[1]) begin
      frame_three_init_out <= 1'b0;
    end
  end
endmodule : frame_pulse_alignment_control

// ---- frame_align_pkg.sv ----
// Register map, field layout and codes for frame pulse alignment control
package frame_align_pkg;
  localparam logic [7:0] frame_one_alignment_control_addr = 8'h11;
  localparam logic [7:0] frame_two_alignment_control_addr = 8'h12;
  localparam logic [7:0] frame_three_alignment_control_addr = 8'h13;
  localparam int align_sel_lsb = 4;
  localparam int resync_lsb = 2;
  localparam int slew_bit = 1;
  localparam int init_bit = 0;
  localparam logic [1:0] align_sel_reset = 2'h3;
  localparam logic [1:0] resync_reset = 2'h1;
  localparam logic slew_reset = 1'b0;
  localparam logic [2:0] window_reset = 3'h2;
  localparam logic [1:0] align_auto = 2'h0;
  localparam logic [1:0] align_one_shot = 2'h1;
  localparam logic [1:0] align_always = 2'h2;
  localparam logic [1:0] align_never = 2'h3;
  localparam int near_lines = 2;
  localparam int line_count_width = 12;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    act_none,
    act_drift,
    act_crash,
    act_slew
  } lock_action_e;

  typedef struct packed {
    logic realign_now;
    logic drift_lock;
    logic crash_lock;
    logic slew_active;
    logic vcxo_rail_high;
  } frame_one_ctl_s;
endpackage : frame_align_pkg

// ---- frame_align_asserts.sv ----
// Port-level assertions for frame pulse alignment control
`timescale 1ns/100ps
module frame_align_asserts #(
  parameter int err_width = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input frame_align_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [err_width-1:0] frame_error,
  input wire logic [2:0] misalign_window_code,
  input wire logic misalign_report,
  input wire logic [1:0] frame_two_mode,
  input wire logic [1:0] frame_three_mode,
  input wire logic frame_two_init_out,
  input wire logic frame_three_init_out
);
  import frame_align_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic w2, w3, i2w, i3w, go2, go3;
  assign w2 = reg_req.wr_en && reg_req.addr == frame_two_alignment_control_addr;
  assign w3 = reg_req.wr_en && reg_req.addr == frame_three_alignment_control_addr;
  assign i2w = w2 && reg_req.wdata[init_bit];
  assign i3w = w3 && reg_req.wdata[init_bit];
  // A never-align select in the same write vetoes the pulse
  assign go2 = i2w && reg_req.wdata[5:4] != align_never;
  assign go3 = i3w && reg_req.wdata[5:4] != align_never;
  property p_rise2; go2 |=> frame_two_init_out; endproperty
  a_rise2: assert property (p_rise2) else $error("second init late");
  property p_rise3; go3 |=> frame_three_init_out; endproperty
  a_rise3: assert property (p_rise3) else $error("third init late");
  property p_veto2; i2w && !go2 && !frame_two_init_out |=> !frame_two_init_out; endproperty
  a_veto2: assert property (p_veto2) else $error("second init not vetoed");
  property p_veto3; i3w && !go3 && !frame_three_init_out |=> !frame_three_init_out; endproperty
  a_veto3: assert property (p_veto3) else $error("third init not vetoed");
  property p_mode2; w2 |=> ##1 frame_two_mode == $past(reg_req.wdata[5:4], 2); endproperty
  a_mode2: assert property (p_mode2) else $error("second mode wrong");
  property p_mode3; w3 |=> ##1 frame_three_mode == $past(reg_req.wdata[5:4], 2); endproperty
  a_mode3: assert property (p_mode3) else $error("third mode wrong");
  property p_rsvd; reg_rvalid |-> (reg_rdata & 8'hc1) == 8'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
  property p_win;
    1'b1 |=> misalign_report == ($past(frame_error) > (32'h1 << $past(misalign_window_code)));
  endproperty
  a_win: assert property (p_win) else $error("misalign report wrong");
  c_pulse2: cover property (go2 ##1 frame_two_init_out);
  c_veto3: cover property (i3w && !go3);
  c_report: cover property (misalign_report);
endmodule : frame_align_asserts

// ---- sync_ref_model.sv ----
// Sync reference model: line and frame ticks timed from the reference
`timescale 1ns/100ps
module sync_ref_model #(
  parameter int line_len = 4,
  parameter int frame_lines = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic line_tick = 1'b0,
  output logic frame_tick = 1'b0
);
  int cyc = 0;
  // Short lines and frames keep pulse checks quick; frame tick lands on a line tick
  always @(negedge sys_clk) begin
    cyc = rst ? 0 : cyc + 1;
    line_tick <= !rst && cyc % line_len == 0;
    frame_tick <= !rst && cyc % (line_len * frame_lines) == 0;
  end
endmodule : sync_ref_model

// ---- frame_pulse_alignment_control_tb.sv ----
// Self-checking bench for frame pulse alignment control
`timescale 1ns/100ps
module frame_pulse_alignment_control_tb;
  import frame_align_pkg::*;
  localparam int line_len = 4;
  localparam int frame_lines = 5;
  localparam int lo = (frame_lines + 1) * line_len;
  logic sys_clk = 0, rst = 1, horizontal_only = 0, reference_loss = 0, same_reference = 1;
  logic [15:0] frame_error = '0;
  logic [2:0] misalign_window_code = 3'h2;
  reg_req_s reg_req = '0;
  logic [7:0] reg_rdata, got;
  logic reg_rvalid, line_tick, frame_tick, misalign_report, i2, i3;
  logic [1:0] m2, m3;
  frame_one_ctl_s ctl;
  logic [4:0] seen;
  logic [7:0] model [3] = '{8'h34, 8'h30, 8'h30};
  // Fields: policy, slew, same ref, error, then expected drift/crash/slew/rail
  logic [15:0] tab [7] = '{16'h1028, 16'h5038, 16'h5044, 16'h9014, 16'hd014, 16'h4c82, 16'h6c83};
  int n_errors = 0, tests_run = 0, seed = 96461, cycles = 0, cnt = 0, c0, d;
  frame_pulse_alignment_control #(.err_width(16)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_tick(line_tick),
    .frame_tick(frame_tick), .horizontal_only(horizontal_only), .reference_loss(reference_loss),
    .same_reference(same_reference), .frame_error(frame_error), .frame_one_ctl(ctl),
    .misalign_window_code(misalign_window_code), .misalign_report(misalign_report),
    .frame_two_mode(m2), .frame_three_mode(m3), .frame_two_init_out(i2), .frame_three_init_out(i3));
  sync_ref_model #(.line_len(line_len), .frame_lines(frame_lines)) i_ref (.sys_clk(sys_clk),
    .rst(rst), .line_tick(line_tick), .frame_tick(frame_tick));
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) cnt += (i2 === 1'b1) + (i3 === 1'b1);
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] v);
    reg_req = '{w, !w, a, v};
    @(negedge sys_clk);
    got = reg_rvalid ? reg_rdata : 8'hee;
    reg_req = '0;
    @(negedge sys_clk);
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a inside {[8'h11:8'h13]}) model[a - 8'h11] = v & (a == 8'h11 ? 8'h3e : 8'h30);
    op(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    op(1'b0, a, 8'h0);
    check(got, a inside {[8'h11:8'h13]} ? model[a - 8'h11] : 8'h0);
  endtask : rd
  task automatic watch();
    seen = '0;
    repeat (40) begin
      @(negedge sys_clk);
      seen |= {ctl.realign_now, ctl.drift_lock, ctl.crash_lock, ctl.slew_active, ctl.vcxo_rail_high};
    end
  endtask : watch
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    for (int a = 8'h11; a < 8'h15; a++) rd(8'(a));
    repeat (6) begin
      d = $random(seed);
      wr(8'h11, d[5:4] == 2'h1 ? d[7:0] ^ 8'h10 : d[7:0]);
      rd(8'h11);
    end
    for (int k = 1; k < 3; k++) begin
      for (int s = 0; s < 4; s++) begin
        d = $random(seed);
        c0 = cnt;
        wr(8'h11 + 8'(k), {d[7:6], 2'(s), d[3:1], 1'b1});
        repeat (40) @(negedge sys_clk);
        check(8'(k == 1 ? m2 : m3), 8'(s));
        check(8'(s == 3 ? cnt - c0 : (cnt - c0 >= lo && cnt - c0 <= lo + line_len)), 8'(s != 3));
        rd(8'h11 + 8'(k));
      end
    end
    repeat (20) begin
      d = $random(seed);
      frame_error = {8'h0, d[7:0]};
      misalign_window_code = d[10:8];
      @(negedge sys_clk);
      check(8'(misalign_report), 8'(frame_error > (16'h1 << misalign_window_code)));
    end
    misalign_window_code = 3'h2;
    foreach (tab[i]) begin
      wr(8'h11, {2'h0, align_auto, tab[i][15:13], 1'b0});
      frame_error = {8'h0, tab[i][11:4]};
      same_reference = tab[i][12];
      reference_loss = 1;
      repeat (25) @(negedge sys_clk);
      reference_loss = 0;
      watch();
      check({4'h0, seen[3:0]}, {4'h0, tab[i][3:0]});
    end
    wr(8'h11, 8'h20);
    watch();
    check(8'(seen[4]), 8'h1);
    horizontal_only = 1;
    wr(8'h11, 8'h20);
    watch();
    check(8'(seen[4]), 8'h0);
    print_verdict();
  end
endmodule : frame_pulse_alignment_control_tb
bind frame_pulse_alignment_control frame_align_asserts #(.err_width(err_width)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .frame_error(frame_error), .misalign_report(misalign_report),
  .misalign_window_code(misalign_window_code), .frame_two_mode(frame_two_mode),
  .frame_three_mode(frame_three_mode), .frame_two_init_out(frame_two_init_out),
  .frame_three_init_out(frame_three_init_out));
